/* File: common/srql_pkg.sv */
// Constants and carrier types for the status reporting and service request block.
package srql_pkg;
  // Widths of the bus, the status byte and the instrument-specific registers.
  localparam int SRQL_AW = 8;
  localparam int SRQL_DW = 32;
  localparam int SRQL_BYTE_W = 8;
  localparam int SRQL_SCPI_W = 16;
  localparam int SRQL_ERR_W = 16;
  localparam int SRQL_ERRQ_DEPTH = 8;
  localparam int SRQL_IRQ_W = 3;
  localparam int SRQL_NSCPI = 2;

  // Byte addresses of the registers.
  localparam logic [7:0] SRQL_OFS_STB = 8'h00;
  localparam logic [7:0] SRQL_OFS_SRE = 8'h04;
  localparam logic [7:0] SRQL_OFS_ESR = 8'h08;
  localparam logic [7:0] SRQL_OFS_ESE = 8'h0C;
  localparam logic [7:0] SRQL_OFS_QUES = 8'h10;
  localparam logic [7:0] SRQL_OFS_OPER = 8'h24;
  localparam logic [7:0] SRQL_OFS_ERRQ = 8'h38;
  localparam logic [7:0] SRQL_OFS_ERRCNT = 8'h3C;
  localparam logic [7:0] SRQL_OFS_CMD = 8'h40;
  localparam logic [7:0] SRQL_OFS_IRQ_STAT = 8'h44;
  localparam logic [7:0] SRQL_OFS_IRQ_MASK = 8'h48;
  localparam logic [7:0] SRQL_OFS_SCPI_SPAN = 8'h10;

  // Word index of each part inside an instrument-specific register group.
  localparam logic [2:0] SRQL_SUB_COND = 3'h0;
  localparam logic [2:0] SRQL_SUB_EVENT = 3'h1;
  localparam logic [2:0] SRQL_SUB_ENABLE = 3'h2;
  localparam logic [2:0] SRQL_SUB_PTR = 3'h3;
  localparam logic [2:0] SRQL_SUB_NTR = 3'h4;

  // Status byte bit positions.
  localparam int SRQL_STB_ERRQ = 2;
  localparam int SRQL_STB_QUES = 3;
  localparam int SRQL_STB_MAV = 4;
  localparam int SRQL_STB_ESB = 5;
  localparam int SRQL_STB_MSS = 6;
  localparam int SRQL_STB_OPER = 7;
  localparam logic [7:0] SRQL_SRQ_BITS = 8'hBC;

  // Command register bit positions.
  localparam int SRQL_CMD_CLS = 0;
  localparam int SRQL_CMD_PRESET = 1;
  localparam int SRQL_CMD_DCL = 2;
  localparam int SRQL_CMD_SETRST = 3;

  // Interrupt status bit positions.
  localparam int SRQL_IRQ_SRQ = 0;
  localparam int SRQL_IRQ_ERR = 1;
  localparam int SRQL_IRQ_OVF = 2;

  // Values after reset.
  localparam logic [7:0] SRQL_ESR_RST = 8'h80;
  localparam logic [7:0] SRQL_SRE_RST = 8'h00;
  localparam logic [7:0] SRQL_ESE_RST = 8'h00;
  localparam logic [15:0] SRQL_ENA_RST = 16'h0000;
  localparam logic [15:0] SRQL_PTR_RST = 16'hFFFF;
  localparam logic [15:0] SRQL_NTR_RST = 16'h0000;
  localparam logic [2:0] SRQL_IRQ_MASK_RST = 3'h0;
  localparam logic SRQL_AFTER_PMT_RST = 1'b1;

  // One register bus request.
  typedef struct packed {
    logic [SRQL_AW-1:0] addr;
    logic [SRQL_DW-1:0] wdata;
    logic wr;
    logic rd;
  } srql_bus_t;

  // One error report from the command or measurement logic.
  typedef struct packed {
    logic push;
    logic [SRQL_ERR_W-1:0] code;
  } srql_err_t;
endpackage

/* File: rtl/srql_scpi_reg.sv */
// One instrument-specific status register group: condition, filters, event and enable.
`timescale 1ns/1ns
module srql_scpi_reg #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Present state of the watched conditions.
  input wire logic [W-1:0] i_cond,
  // Register access and status commands.
  input wire logic i_wr,
  input wire logic [2:0] i_sel,
  input wire logic [W-1:0] i_wdata,
  input wire logic i_evt_rd,
  input wire logic i_cls,
  input wire logic i_preset,
  // Register contents and summary.
  output logic [W-1:0] o_cond,
  output logic [W-1:0] o_event,
  output logic [W-1:0] o_enable,
  output logic [W-1:0] o_ptr,
  output logic [W-1:0] o_ntr,
  output logic o_summary
);
  import srql_pkg::*;

  // All state of the group.
  typedef struct packed {
    logic [W-1:0] cond;
    logic [W-1:0] event_bits;
    logic [W-1:0] enable;
    logic [W-1:0] ptr;
    logic [W-1:0] ntr;
  } srql_scpi_st_t;

  srql_scpi_st_t s_r;
  srql_scpi_st_t s_nxt;
  logic [W-1:0] evt_set; // Transitions that pass the filters this cycle.

  // Edge filtering, event latching and the effects of commands.
  always_comb begin
    s_nxt = s_r;
    s_nxt.cond = i_cond;
    evt_set = (i_cond & ~s_r.cond & s_r.ptr) | (~i_cond & s_r.cond & s_r.ntr);
    // A read empties the event part, but an edge in the same cycle survives.
    if (i_evt_rd) begin
      s_nxt.event_bits = '0;
    end
    s_nxt.event_bits = s_nxt.event_bits | evt_set;
    if (i_wr) begin
      case (i_sel)
        SRQL_SUB_ENABLE: s_nxt.enable = i_wdata;
        SRQL_SUB_PTR: s_nxt.ptr = i_wdata;
        SRQL_SUB_NTR: s_nxt.ntr = i_wdata;
        default: s_nxt.enable = s_nxt.enable;
      endcase
    end
    // Clear-status beats any edge arriving alongside it; masks are kept.
    if (i_cls) begin
      s_nxt.event_bits = '0;
    end
    // Preset leaves only rising edges armed and every summary closed.
    if (i_preset) begin
      s_nxt.enable = '0;
      s_nxt.ptr = '1;
      s_nxt.ntr = '0;
    end
  end

  // State register.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      s_r <= '{cond: '0, event_bits: '0, enable: W'(SRQL_ENA_RST),
               ptr: W'(SRQL_PTR_RST), ntr: W'(SRQL_NTR_RST)};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_cond = s_r.cond;
  assign o_event = s_r.event_bits;
  assign o_enable = s_r.enable;
  assign o_ptr = s_r.ptr;
  assign o_ntr = s_r.ntr;
  assign o_summary = |(s_r.event_bits & s_r.enable);
endmodule

/* File: rtl/srql_top.sv */
// Status byte, event registers, error queue and service request generation.
//
// Summary of operation
// - Request service when enabled bits 2,3,4,5,7 set.
// - Summary bits come from registers, queue, buffer.
// - Status byte and event status are eight bits.
// - Reads return plain binary weighted bit sums.
// - Bit 3 questionable, bit 5 event status.
// - Enable masks let bits 2,3,4,5,7 reach request; bit 6 never does.
// - Each detected error pushes one queue entry unless clear-status comes or the queue is full with no pop in that cycle.
// - Clear-status zeroes events, queue; masks kept.
// - Preset zeroes operation and questionable enables.
// - Preset sets positive filters, clears negative ones.
// - Device clear flushes buffers, aborts, keeps status.
// - New line's first command empties output buffer.
// - Only settings reset touches instrument settings.
// - Condition part live, event part cleared on read.
`timescale 1ns/1ns
module srql_top #(
  parameter int ERRQ_DEPTH = srql_pkg::SRQL_ERRQ_DEPTH
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Register bus request and read answer.
  input wire srql_pkg::srql_bus_t i_bus,
  output logic [srql_pkg::SRQL_DW-1:0] o_rdata,
  // Internal event sources.
  input wire logic [srql_pkg::SRQL_SCPI_W-1:0] i_ques_cond,
  input wire logic [srql_pkg::SRQL_SCPI_W-1:0] i_oper_cond,
  input wire logic [srql_pkg::SRQL_BYTE_W-1:0] i_esr_evt,
  input wire srql_pkg::srql_err_t i_err,
  input wire logic i_obuf_avail,
  // Command line framing from the parser.
  input wire logic i_pmt,
  input wire logic i_cmd_start,
  // Service request and interrupt.
  output logic o_srq,
  output logic o_irq,
  // Actions on the parser, buffers and settings.
  output logic o_obuf_clear,
  output logic o_cmd_abort,
  output logic o_ibuf_clear,
  output logic o_settings_rst
);
  import srql_pkg::*;

  // Deeper queues cost storage; the pointers grow only by log2.
  localparam int IW = $clog2(ERRQ_DEPTH); // Width of a queue index.

  // The queue pointer arithmetic wraps by bit width, so depth is a power of two.
  if (ERRQ_DEPTH < 2 || (1 << IW) != ERRQ_DEPTH) begin : g_depth_check
    $error("ERRQ_DEPTH must be a power of two of at least 2");
  end

  // Everything that lasts past one cycle, except the group registers, lives in this record.
  // The reset branch and the register below cannot miss a field,
  // and a new field is reset as soon as it is declared.
  // All state of the block outside the two register groups.
  typedef struct packed {
    logic [SRQL_BYTE_W-1:0] sre;
    logic [SRQL_BYTE_W-1:0] esr;
    logic [SRQL_BYTE_W-1:0] ese;
    // Queue storage, oldest entry and fill level; the level has one
    // more bit than an index, so full and empty differ.
    logic [ERRQ_DEPTH-1:0][SRQL_ERR_W-1:0] errq;
    logic [IW-1:0] head;
    logic [IW:0] count;
    logic [SRQL_IRQ_W-1:0] irq_stat;
    logic [SRQL_IRQ_W-1:0] irq_mask;
    logic after_pmt;
    // Registered copies of the outputs, renewed on every edge.
    logic srq;
    logic irq;
    logic [SRQL_DW-1:0] rdata;
    logic obuf_clear;
    logic cmd_abort;
    logic ibuf_clear;
    logic settings_rst;
  } srql_st_t;

  srql_st_t s_r;
  srql_st_t s_nxt;

  // The groups keep their own state; these arrays only carry it
  // to the read multiplexer and add no storage.
  // Per-group views of the two instrument-specific registers.
  logic [SRQL_SCPI_W-1:0] g_cond [SRQL_NSCPI];
  logic [SRQL_SCPI_W-1:0] g_event [SRQL_NSCPI];
  logic [SRQL_SCPI_W-1:0] g_enable [SRQL_NSCPI];
  logic [SRQL_SCPI_W-1:0] g_ptr [SRQL_NSCPI];
  logic [SRQL_SCPI_W-1:0] g_ntr [SRQL_NSCPI];
  logic [SRQL_NSCPI-1:0] g_sum; // Summary of each group.
  logic [SRQL_NSCPI-1:0] g_hit; // Bus address falls in the group.
  logic [2:0] g_sel [SRQL_NSCPI]; // Part index inside the group.

  // Decoded strobes and summaries shared by the processes below.
  logic cmd_wr; // Write to the command register.
  logic cls; // Clear-status command this cycle.
  logic preset; // Status preset command this cycle.
  logic [SRQL_BYTE_W-1:0] stb; // Status byte as software sees it.
  logic srq_now; // Enabled summary bit present.
  logic errq_pop; // Read of the queue head with an entry present.
  logic errq_full; // Queue holds its full depth.

  // Several command bits in one write all act on one edge.
  // Clear-status and preset fan out to both groups at once.
  // Commands arrive as one-cycle writes to the command register.
  assign cmd_wr = i_bus.wr && (i_bus.addr == SRQL_OFS_CMD);
  assign cls = cmd_wr && i_bus.wdata[SRQL_CMD_CLS];
  assign preset = cmd_wr && i_bus.wdata[SRQL_CMD_PRESET];

  // Each group spans five words. Only aligned addresses inside
  // the span are claimed, so a stray byte address reads zero
  // instead of aliasing onto a neighbouring part.
  // Questionable group first, operation group second.
  for (genvar g = 0; g < SRQL_NSCPI; g++) begin : g_scpi
    localparam logic [7:0] BASE = (g == 0) ? SRQL_OFS_QUES : SRQL_OFS_OPER;
    logic [7:0] rel;
    assign rel = i_bus.addr - BASE;
    assign g_hit[g] = (i_bus.addr >= BASE) && (rel <= SRQL_OFS_SCPI_SPAN)
                      && (rel[1:0] == 2'b00);
    assign g_sel[g] = rel[4:2];
    srql_scpi_reg #(.W(SRQL_SCPI_W)) u_reg (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_cond((g == 0) ? i_ques_cond : i_oper_cond),
      .i_wr(i_bus.wr && g_hit[g]),
      .i_sel(g_sel[g]),
      .i_wdata(i_bus.wdata[SRQL_SCPI_W-1:0]),
      .i_evt_rd(i_bus.rd && g_hit[g] && (g_sel[g] == SRQL_SUB_EVENT)),
      .i_cls(cls),
      .i_preset(preset),
      .o_cond(g_cond[g]),
      .o_event(g_event[g]),
      .o_enable(g_enable[g]),
      .o_ptr(g_ptr[g]),
      .o_ntr(g_ntr[g]),
      .o_summary(g_sum[g])
    );
  end

  // Bit 6 reports the request condition itself. It is masked out
  // of its own term, so it never holds itself up.
  // The price is one more logic level before the request register.
  // The status byte is built fresh each cycle, so clearing its sources clears it.
  always_comb begin
    stb = '0;
    stb[SRQL_STB_ERRQ] = (s_r.count != '0);
    stb[SRQL_STB_QUES] = g_sum[0];
    stb[SRQL_STB_MAV] = i_obuf_avail;
    stb[SRQL_STB_ESB] = |(s_r.esr & s_r.ese);
    stb[SRQL_STB_OPER] = g_sum[1];
    srq_now = |(stb & s_r.sre & SRQL_SRQ_BITS);
    stb[SRQL_STB_MSS] = srq_now;
  end

  // A read of an empty queue pops nothing and answers zero, so
  // software may poll the head until it reads zero.
  assign errq_pop = i_bus.rd && (i_bus.addr == SRQL_OFS_ERRQ) && (s_r.count != '0);
  assign errq_full = (s_r.count == (IW + 1)'(ERRQ_DEPTH));

  // Register writes, event latching, the error queue and command side effects.
  always_comb begin
    logic [IW-1:0] wr_idx;
    logic push_ok;
    wr_idx = '0;
    push_ok = 1'b0;
    s_nxt = s_r;
    s_nxt.obuf_clear = 1'b0;
    s_nxt.cmd_abort = 1'b0;
    s_nxt.ibuf_clear = 1'b0;
    s_nxt.settings_rst = 1'b0;
    s_nxt.rdata = '0;
    // Pulses and read data fall back to zero unless set below,
    // so each stands for exactly one cycle.
    // Mask registers written by software.
    if (i_bus.wr) begin
      case (i_bus.addr)
        SRQL_OFS_SRE: s_nxt.sre = i_bus.wdata[SRQL_BYTE_W-1:0];
        SRQL_OFS_ESE: s_nxt.ese = i_bus.wdata[SRQL_BYTE_W-1:0];
        SRQL_OFS_IRQ_MASK: s_nxt.irq_mask = i_bus.wdata[SRQL_IRQ_W-1:0];
        SRQL_OFS_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~i_bus.wdata[SRQL_IRQ_W-1:0];
        default: s_nxt.sre = s_nxt.sre;
      endcase
    end
    // The group spans never overlap the byte registers, but the group
    // decode must come after the byte decode, whose default arm zeroes the answer.
    // Read answer, one cycle after the strobe; values are plain binary sums.
    if (i_bus.rd) begin
      case (i_bus.addr)
        SRQL_OFS_STB: s_nxt.rdata = SRQL_DW'(stb);
        SRQL_OFS_SRE: s_nxt.rdata = SRQL_DW'(s_r.sre);
        SRQL_OFS_ESR: s_nxt.rdata = SRQL_DW'(s_r.esr);
        SRQL_OFS_ESE: s_nxt.rdata = SRQL_DW'(s_r.ese);
        SRQL_OFS_ERRQ: s_nxt.rdata = errq_pop ? SRQL_DW'(s_r.errq[s_r.head]) : '0;
        SRQL_OFS_ERRCNT: s_nxt.rdata = SRQL_DW'(s_r.count);
        SRQL_OFS_IRQ_STAT: s_nxt.rdata = SRQL_DW'(s_r.irq_stat);
        SRQL_OFS_IRQ_MASK: s_nxt.rdata = SRQL_DW'(s_r.irq_mask);
        default: s_nxt.rdata = '0;
      endcase
      // Sixteen-bit groups answer at their own offsets.
      for (int g = 0; g < SRQL_NSCPI; g++) begin
        if (g_hit[g]) begin
          case (g_sel[g])
            SRQL_SUB_COND: s_nxt.rdata = SRQL_DW'(g_cond[g]);
            SRQL_SUB_EVENT: s_nxt.rdata = SRQL_DW'(g_event[g]);
            SRQL_SUB_ENABLE: s_nxt.rdata = SRQL_DW'(g_enable[g]);
            SRQL_SUB_PTR: s_nxt.rdata = SRQL_DW'(g_ptr[g]);
            SRQL_SUB_NTR: s_nxt.rdata = SRQL_DW'(g_ntr[g]);
            default: s_nxt.rdata = '0;
          endcase
        end
      end
    end
    // Software never loses an event this way: one that comes with
    // the read shows up in the next read.
    // Event status: read clears it, but an event in the same cycle is kept.
    if (i_bus.rd && (i_bus.addr == SRQL_OFS_ESR)) begin
      s_nxt.esr = '0;
    end
    s_nxt.esr = s_nxt.esr | i_esr_evt;
    // A full queue drops the new error and only the error and overflow
    // flags record it. The oldest entries are kept, because the first
    // error usually names the cause and later ones echo it.
    // Error queue: a pop frees a slot for a push in the same cycle.
    if (errq_pop) begin
      s_nxt.head = s_r.head + 1'b1;
    end
    if (i_err.push) begin
      push_ok = !errq_full || errq_pop;
      wr_idx = s_r.head + s_r.count[IW-1:0];
      if (push_ok) begin
        s_nxt.errq[wr_idx] = i_err.code;
      end
    end
    s_nxt.count = s_r.count + (IW + 1)'(push_ok) - (IW + 1)'(errq_pop);
    // The request cause is taken on the rising edge, so a request
    // that stays up raises the interrupt only once.
    // Sticky interrupt causes; a new event beats a write-one clear.
    s_nxt.irq_stat[SRQL_IRQ_SRQ] = s_nxt.irq_stat[SRQL_IRQ_SRQ] | (srq_now & ~s_r.srq);
    s_nxt.irq_stat[SRQL_IRQ_ERR] = s_nxt.irq_stat[SRQL_IRQ_ERR] | i_err.push;
    s_nxt.irq_stat[SRQL_IRQ_OVF] = s_nxt.irq_stat[SRQL_IRQ_OVF] | (i_err.push & ~push_ok);
    // A terminator beside a command start leaves the flush armed,
    // so the next command still counts as a line's first.
    // A terminator arms the flush for the next line's first command.
    if (i_pmt) begin
      s_nxt.after_pmt = 1'b1;
    end
    if (i_cmd_start && s_r.after_pmt) begin
      s_nxt.obuf_clear = 1'b1;
      s_nxt.after_pmt = i_pmt;
    end
    // Clear-status comes after every set above, so an event in the
    // same cycle is lost; software clears after reading.
    // Clear-status overrides events and queue entries latched this cycle; interrupt flags and masks untouched.
    if (cls) begin
      s_nxt.esr = '0;
      s_nxt.count = '0;
      s_nxt.head = '0;
    end
    // Device clear recovers a stuck parser; keeping status lets
    // software still find out what went wrong.
    // Device clear reaches only the buffers and the parser, never status.
    if (cmd_wr && i_bus.wdata[SRQL_CMD_DCL]) begin
      s_nxt.obuf_clear = 1'b1;
      s_nxt.cmd_abort = 1'b1;
      s_nxt.ibuf_clear = 1'b1;
    end
    // Only the full reset command reaches the instrument settings.
    s_nxt.settings_rst = cmd_wr && i_bus.wdata[SRQL_CMD_SETRST];
    // The request is rebuilt each cycle rather than held, so it
    // drops one cycle after its last enabled cause goes.
    // Request and interrupt follow the present state every cycle.
    s_nxt.srq = srq_now;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  // Reset is synchronous and holds only constants. The flush starts
  // armed, so the first command after power-up empties the
  // output buffer.
  // State register with constant reset values.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      s_r <= '0;
      s_r.sre <= SRQL_SRE_RST;
      s_r.esr <= SRQL_ESR_RST;
      s_r.ese <= SRQL_ESE_RST;
      s_r.irq_mask <= SRQL_IRQ_MASK_RST;
      s_r.after_pmt <= SRQL_AFTER_PMT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // No logic follows the register, so the parser and buffers see
  // clean one-cycle pulses with a full cycle to settle.
  // Outputs come straight from the state register.
  assign o_rdata = s_r.rdata;
  assign o_srq = s_r.srq;
  assign o_irq = s_r.irq;
  assign o_obuf_clear = s_r.obuf_clear;
  assign o_cmd_abort = s_r.cmd_abort;
  assign o_ibuf_clear = s_r.ibuf_clear;
  assign o_settings_rst = s_r.settings_rst;
endmodule

/* File: sim/srql_top_sva.sv */
// Checker for the service request block, bound to its top module.
`timescale 1ns/1ns
module srql_top_chk #(
  parameter int ERRQ_DEPTH = 8
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Bus and framing inputs.
  input wire srql_pkg::srql_bus_t i_bus,
  input wire logic i_obuf_avail,
  input wire logic i_pmt,
  input wire logic i_cmd_start,
  // Outputs under watch.
  input wire logic [srql_pkg::SRQL_DW-1:0] o_rdata,
  input wire logic o_srq,
  input wire logic o_obuf_clear,
  input wire logic o_cmd_abort,
  input wire logic o_ibuf_clear,
  input wire logic o_settings_rst
);
  import srql_pkg::*;
  // Mirror of the request mask and of the flush arming, taken from the inputs.
  logic [7:0] sre_r;
  logic armed_r;
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      sre_r <= 8'h00;
      armed_r <= 1'b1;
    end else begin
      if (i_bus.wr && i_bus.addr == SRQL_OFS_SRE) sre_r <= i_bus.wdata[7:0];
      if (i_pmt) armed_r <= 1'b1;
      else if (i_cmd_start) armed_r <= 1'b0;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // A write of one command bit to the command register.
  sequence s_cmd_wr(int b);
    i_bus.wr && i_bus.addr == SRQL_OFS_CMD && i_bus.wdata[b];
  endsequence
  // All three flush actions together.
  sequence s_flush;
    o_obuf_clear && o_cmd_abort && o_ibuf_clear;
  endsequence
  a_dcl_flushes_all: assert property (s_cmd_wr(SRQL_CMD_DCL) |=> s_flush)
    else $error("device clear did not flush and abort");
  a_abort_has_cause: assert property (o_cmd_abort |->
    $past(i_bus.wr && i_bus.addr == SRQL_OFS_CMD && i_bus.wdata[SRQL_CMD_DCL]))
    else $error("abort without device clear");
  a_settings_cause: assert property (o_settings_rst |->
    $past(i_bus.wr && i_bus.addr == SRQL_OFS_CMD && i_bus.wdata[SRQL_CMD_SETRST]))
    else $error("settings reset without its command");
  a_line_flush: assert property (i_cmd_start && armed_r |=> o_obuf_clear)
    else $error("first command of a line did not flush");
  a_rdata_idle: assert property (!i_bus.rd |=> o_rdata == '0)
    else $error("read data outside its cycle");
  a_rdata_width: assert property (i_bus.rd |=> o_rdata[31:16] == 16'h0000)
    else $error("read data wider than any register");
  a_srq_drops: assert property ((sre_r == 8'h00) [*3] |-> !o_srq)
    else $error("request while mask is empty");
  a_srq_obuf: assert property ((sre_r[SRQL_STB_MAV] && i_obuf_avail) [*3] |-> o_srq)
    else $error("no request for output data");
endmodule
bind srql_top srql_top_chk #(.ERRQ_DEPTH(ERRQ_DEPTH)) u_chk (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_bus(i_bus), .i_obuf_avail(i_obuf_avail),
  .i_pmt(i_pmt), .i_cmd_start(i_cmd_start), .o_rdata(o_rdata), .o_srq(o_srq),
  .o_obuf_clear(o_obuf_clear), .o_cmd_abort(o_cmd_abort), .o_ibuf_clear(o_ibuf_clear),
  .o_settings_rst(o_settings_rst));

/* File: sim/srql_ctrl_model.sv */
// Controller model that issues register bus cycles toward the block.
`timescale 1ns/1ns
module srql_ctrl_model (
  // Clock.
  input wire logic i_core_clk,
  // Read answer from the block.
  input wire logic [srql_pkg::SRQL_DW-1:0] i_rdata,
  // Bus request toward the block.
  output srql_pkg::srql_bus_t o_bus
);
  import srql_pkg::*;
  initial o_bus = '0;
  // One write cycle; idle lines are inverted so a stale value never looks valid.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_core_clk);
    o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  // One read cycle; the answer is taken in the cycle after the strobe.
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    o_bus <= '{addr: a, wdata: ~o_bus.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge i_core_clk);
    o_bus <= '{addr: ~a, wdata: o_bus.wdata, wr: 1'b0, rd: 1'b0};
    #1 d = i_rdata;
  endtask
  // Opens both masks fully so every summary can raise a request.
  task automatic set_masks();
    bus_wr(SRQL_OFS_SRE, 32'hFF);
    bus_wr(SRQL_OFS_ESE, 32'hFF);
  endtask
endmodule

/* File: sim/srql_top_tb.sv */
// Self-checking bench for the status reporting and service request block.
`timescale 1ns/1ns
module srql_top_tb;
  import srql_pkg::*;
  localparam int DEPTH = 4;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  srql_bus_t bus;
  logic [31:0] rdata;
  logic [15:0] ques = '0;
  logic [15:0] oper = '0;
  logic [7:0] evt = '0;
  srql_err_t err = '0;
  logic obuf = 1'b0;
  logic pmt = 1'b0;
  logic cstart = 1'b0;
  logic srq, irq, oclr, abrt, iclr, srst;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] rnd = 32'h3B83;
  logic [31:0] d;
  logic [7:0] e;
  logic [15:0] q;
  logic [15:0] codes [3];
  logic [7:0] grp [2] = '{SRQL_OFS_QUES, SRQL_OFS_OPER};
  // Core clock at 50 MHz.
  always #10 i_core_clk = ~i_core_clk;
  srql_top #(.ERRQ_DEPTH(DEPTH)) dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_bus(bus),
    .o_rdata(rdata), .i_ques_cond(ques), .i_oper_cond(oper), .i_esr_evt(evt), .i_err(err),
    .i_obuf_avail(obuf), .i_pmt(pmt), .i_cmd_start(cstart), .o_srq(srq), .o_irq(irq),
    .o_obuf_clear(oclr), .o_cmd_abort(abrt), .o_ibuf_clear(iclr), .o_settings_rst(srst));
  srql_ctrl_model ctrl (.i_core_clk(i_core_clk), .i_rdata(rdata), .o_bus(bus));
  // Next value of the random sequence.
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected status byte: request bits kept, the master bit from the mask.
  function automatic logic [31:0] stb_exp(logic [7:0] sum, logic [7:0] sre);
    logic [7:0] s;
    s = sum & SRQL_SRQ_BITS;
    s[SRQL_STB_MSS] = |(s & sre);
    return {24'h0, s};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ctrl.bus_rd(a, d);
    chk(d, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // One error report; the code is inverted once the push is gone.
  task automatic pulse_err(input logic [15:0] c);
    @(posedge i_core_clk);
    err <= '{push: 1'b1, code: c};
    @(posedge i_core_clk);
    err <= '{push: 1'b0, code: ~c};
  endtask
  task automatic complete_run();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence of scenarios.
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    rd_chk(SRQL_OFS_ESR, 32'h80);
    rd_chk(SRQL_OFS_ESR, 32'h0);
    rd_chk(SRQL_OFS_QUES + 8'h0C, 32'hFFFF);
    rd_chk(8'hFC, 32'h0);
    ctrl.set_masks();
    rnd = lfsr(rnd);
    e = rnd[7:0] | 8'h01;
    q = rnd[23:8] | 16'h0001;
    @(posedge i_core_clk);
    evt <= e;
    ques <= q;
    oper <= rnd[31:16];
    @(posedge i_core_clk);
    evt <= 8'h00;
    ctrl.bus_wr(SRQL_OFS_QUES + 8'h08, 32'hFFFF);
    idle(3);
    #1 chk(srq, 1);
    rd_chk(SRQL_OFS_STB, stb_exp(8'h28, 8'hFF));
    rd_chk(SRQL_OFS_QUES, {16'h0, q});
    rd_chk(SRQL_OFS_QUES + 8'h04, {16'h0, q});
    rd_chk(SRQL_OFS_QUES + 8'h04, 32'h0);
    rd_chk(SRQL_OFS_STB, stb_exp(8'h20, 8'hFF));
    // Clear-status beats an error pushed in the same cycle.
    fork
      pulse_err(16'h1234);
      ctrl.bus_wr(SRQL_OFS_CMD, 32'h1);
    join
    rd_chk(SRQL_OFS_ERRCNT, 32'h0);
    rd_chk(SRQL_OFS_STB, 32'h0);
    chk(srq, 0);
    rd_chk(SRQL_OFS_ESE, 32'hFF);
    ctrl.bus_rd(SRQL_OFS_SRE, d);
    chk(d & 32'hBC, 32'hBC);
    // Errors raise a request and an interrupt, then are read back in order.
    ctrl.bus_wr(SRQL_OFS_IRQ_MASK, 32'h2);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      codes[i] = rnd[15:0];
      pulse_err(codes[i]);
    end
    idle(2);
    #1 chk({srq, irq}, 2'h3);
    rd_chk(SRQL_OFS_ERRCNT, 32'h3);
    for (int i = 0; i < 3; i++) rd_chk(SRQL_OFS_ERRQ, {16'h0, codes[i]});
    rd_chk(SRQL_OFS_ERRQ, 32'h0);
    ctrl.bus_wr(SRQL_OFS_IRQ_STAT, 32'h7);
    idle(2);
    #1 chk({srq, irq}, 2'h0);
    for (int i = 0; i <= DEPTH; i++) pulse_err(16'h00A5);
    rd_chk(SRQL_OFS_ERRCNT, 32'(DEPTH));
    rd_chk(SRQL_OFS_IRQ_STAT, 32'h7);
    chk(irq, 1);
    ctrl.bus_wr(SRQL_OFS_CMD, 32'h1);
    // Preset restores enables and transition filters in both groups.
    foreach (grp[g]) begin
      ctrl.bus_wr(grp[g] + 8'h08, 32'hFFFF);
      ctrl.bus_wr(grp[g] + 8'h0C, 32'h0);
      ctrl.bus_wr(grp[g] + 8'h10, 32'hFFFF);
    end
    ctrl.bus_wr(SRQL_OFS_CMD, 32'h2);
    foreach (grp[g]) begin
      rd_chk(grp[g] + 8'h08, 32'h0);
      rd_chk(grp[g] + 8'h0C, 32'hFFFF);
      rd_chk(grp[g] + 8'h10, 32'h0);
    end
    // Operation summary reaches bit 7; the negative filter takes falls.
    ctrl.bus_wr(SRQL_OFS_OPER + 8'h08, 32'hFFFF);
    @(posedge i_core_clk);
    oper <= q;
    idle(3);
    rd_chk(SRQL_OFS_STB, stb_exp(8'h80, 8'hFF));
    rd_chk(SRQL_OFS_OPER + 8'h04, {16'h0, q});
    ctrl.bus_wr(SRQL_OFS_OPER + 8'h0C, 32'h0);
    ctrl.bus_wr(SRQL_OFS_OPER + 8'h10, 32'hFFFF);
    @(posedge i_core_clk);
    oper <= 16'h0;
    idle(2);
    rd_chk(SRQL_OFS_OPER + 8'h04, {16'h0, q});
    idle(1);
    #1 chk(srq, 0);
    @(posedge i_core_clk);
    obuf <= 1'b1;
    idle(3);
    #1 chk(srq, 1);
    @(posedge i_core_clk);
    obuf <= 1'b0;
    // Only the first command after reset or after a terminator flushes the output buffer.
    for (int i = 0; i < 3; i++) begin
      @(posedge i_core_clk);
      pmt <= (i == 2);
      @(posedge i_core_clk);
      pmt <= 1'b0;
      cstart <= 1'b1;
      @(posedge i_core_clk);
      cstart <= 1'b0;
      #1 chk(oclr, i != 1);
    end
    ctrl.bus_wr(SRQL_OFS_CMD, 32'h4);
    #1 chk({oclr, abrt, iclr, srst}, 4'hE);
    ctrl.bus_wr(SRQL_OFS_CMD, 32'h8);
    #1 chk({oclr, abrt, iclr, srst}, 4'h1);
    rd_chk(SRQL_OFS_ESE, 32'hFF);
    complete_run();
  end
  // Watchdog well beyond the 150 or so cycles the scenarios need.
  initial begin
    idle(3000);
    err_count++;
    complete_run();
  end
endmodule
